// [hw/sphp_top.sv]
// Parallel host port between host card and waveform memory
`timescale 1ns/1ps
`default_nettype none
module sphp_top #(
  parameter int ADDR_W = 12,
  parameter int FIFO_D = sphp_pkg::FIFO_DEPTH
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [ADDR_W-1:0] memAddr, // Sample memory address
  output logic memRead, // Memory read pulse
  output logic memWrite, // Memory write pulse
  output logic [11:0] memWrSample, // Sample to memory
  output logic memWrNorm, // Norm bit to memory
  input wire logic [11:0] memRdSample, // Sample from memory
  input wire logic memRdNorm, // Norm bit from memory
  input wire logic [ADDR_W-1:0] screenLeft, // Leftmost displayed point
  input wire logic [ADDR_W-1:0] screenStep, // Step between points
  input wire logic diskActivePin, // Disk busy, async
  output logic ioActive, // I/O active indicator
  output logic diskInhibit, // Holds disk off
  output logic plugLive, // Plug-in live request
  output logic plugHoldNext // Plug-in hold-next request
);
  sphp_pkg::sphp_mode_type mode_r, mode_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [ADDR_W-1:0] memAddr_r, memAddr_nxt;
  logic expectAddr_r, expectAddr_nxt;
  logic ioActive_r, ioActive_nxt, live_r, live_nxt, hold_r, hold_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic wait_r, wait_nxt;
  logic memRd_r, memRd_nxt, memWr_r, memWr_nxt;
  logic [11:0] wrSample_r, wrSample_nxt;
  logic wrNorm_r, wrNorm_nxt;
  logic pendRd_r, pendRd_nxt;
  logic diskMeta_r, diskSync_r;
  logic [1:0] cfg_r, cfg_nxt;
  logic fInValid, fInReady, fOutValid, fOutReady;
  logic [15:0] fInData, fOutData;
  logic memRdSeen_r;
  logic ctrlWr, dataWr, dataRd, diskAct, anyLive;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diskMeta_r <= 1'b0;
      diskSync_r <= 1'b0;
    end else begin
      diskMeta_r <= diskActivePin;
      diskSync_r <= diskMeta_r;
    end
  end

  // Incoming words queue here; the memory side drains them
  sphp_fifo #(.WIDTH(16), .DEPTH(FIFO_D)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(fInValid),
    .inReady(fInReady),
    .inData(fInData),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOutData)
  );

  always_comb begin
    ctrlWr = avs_write && avs_address == sphp_pkg::REG_CTRL && wait_r;
    dataWr = avs_write && avs_address == sphp_pkg::REG_DATA && wait_r;
    dataRd = avs_read && avs_address == sphp_pkg::REG_DATA && wait_r;
    diskAct = diskSync_r || cfg_r[sphp_pkg::CFG_DISK];
    anyLive = live_r || cfg_r[sphp_pkg::CFG_LIVE];
    fInData = avs_writedata[15:0];
    // A write waits while the queue is full
    fInValid = dataWr && fInReady;
    // Reads wait until queued writes reach memory, keeping order
    fOutReady = !memWr_r;
  end

  always_comb begin
    mode_nxt = mode_r;
    addr_nxt = addr_r;
    expectAddr_nxt = expectAddr_r;
    ioActive_nxt = ioActive_r;
    live_nxt = live_r;
    hold_nxt = hold_r;
    cfg_nxt = cfg_r;
    if (ctrlWr) begin
      unique case (avs_writedata[15:0])
        sphp_pkg::CTRL_ADV: begin
          mode_nxt = sphp_pkg::SPHP_ADV;
          addr_nxt = '0;
          ioActive_nxt = 1'b1;
        end
        sphp_pkg::CTRL_LOAD: begin
          if (mode_r == sphp_pkg::SPHP_ADV) begin
            mode_nxt = sphp_pkg::SPHP_LOAD;
            expectAddr_nxt = 1'b1;
          end
        end
        sphp_pkg::CTRL_LIVE: begin
          live_nxt = 1'b1;
          hold_nxt = 1'b0;
        end
        sphp_pkg::CTRL_HOLD: begin
          hold_nxt = 1'b1;
          live_nxt = 1'b0;
        end
        sphp_pkg::CTRL_IDLE: begin
          mode_nxt = sphp_pkg::SPHP_IDLE;
          ioActive_nxt = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (avs_write && avs_address == sphp_pkg::REG_CFG && wait_r) begin
      cfg_nxt = avs_writedata[1:0];
    end
    // Drained words: address word or data word
    if (fOutValid && fOutReady) begin
      if (mode_r == sphp_pkg::SPHP_LOAD && expectAddr_r) begin
        // Word arrives doubled; bit 0 is dropped
        addr_nxt = fOutData[ADDR_W:1] ^ sphp_pkg::ADDR_START;
        expectAddr_nxt = 1'b0;
      end else if (mode_r == sphp_pkg::SPHP_LOAD) begin
        expectAddr_nxt = 1'b1;
      end
    end
    if (memRdSeen_r && mode_r == sphp_pkg::SPHP_LOAD) begin
      expectAddr_nxt = 1'b1;
    end else if ((memRdSeen_r || memWr_r) && !ctrlWr
        && mode_r == sphp_pkg::SPHP_ADV) begin
      // Step after the access so a word lands on its own point
      addr_nxt = addr_r + 1'b1;
    end
    // Registered so the pin address cannot glitch
    memAddr_nxt = (mode_nxt == sphp_pkg::SPHP_ADV)
        ? ADDR_W'(screenLeft + addr_nxt * screenStep) : addr_nxt;
  end

  always_comb begin
    rdData_nxt = rdData_r;
    wait_nxt = 1'b1;
    memRd_nxt = 1'b0;
    memWr_nxt = 1'b0;
    wrSample_nxt = wrSample_r;
    wrNorm_nxt = wrNorm_r;
    pendRd_nxt = pendRd_r;
    if (fOutValid && fOutReady && !(mode_r == sphp_pkg::SPHP_LOAD
        && expectAddr_r) && mode_r != sphp_pkg::SPHP_IDLE) begin
      memWr_nxt = 1'b1;
      wrSample_nxt = fOutData[12:1];
      wrNorm_nxt = fOutData[sphp_pkg::NORM_POS];
    end
    if (pendRd_r && memRdSeen_r) begin
      // One word per exchange, held until taken
      rdData_nxt = {16'h0000, {4{memRdSample[sphp_pkg::SIGN_POS]}},
                    memRdSample[10:0], memRdNorm};
      wait_nxt = 1'b0;
      pendRd_nxt = 1'b0;
    end else if (pendRd_r) begin
      wait_nxt = 1'b1;
    end else if (wait_r && (avs_read || avs_write)) begin
      wait_nxt = 1'b0;
      rdData_nxt = sphp_pkg::RST_ZERO;
      if (avs_read) begin
        unique case (avs_address)
          sphp_pkg::REG_STAT: begin
            unique case ({anyLive, diskAct})
              2'b00: rdData_nxt = {16'h0000, sphp_pkg::STAT_NONE};
              2'b10: rdData_nxt = {16'h0000, sphp_pkg::STAT_LIVE};
              2'b01: rdData_nxt = {16'h0000, sphp_pkg::STAT_DISK};
              default: rdData_nxt = {16'h0000, sphp_pkg::STAT_BOTH};
            endcase
          end
          sphp_pkg::REG_CFG: rdData_nxt = {30'h0, cfg_r};
          sphp_pkg::REG_CTRL: rdData_nxt = {29'h0, mode_r};
          default: rdData_nxt = sphp_pkg::RST_ZERO;
        endcase
        if (dataRd) begin
          // Wait for queue to drain, then fetch
          wait_nxt = 1'b1;
          if (!fOutValid && !memWr_r) begin
            pendRd_nxt = 1'b1;
            memRd_nxt = 1'b1;
          end
        end
      end else if (dataWr && !fInReady) begin
        wait_nxt = 1'b1;
      end
    end
    if (!wait_r) begin
      wait_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= sphp_pkg::SPHP_IDLE;
      addr_r <= '0;
      memAddr_r <= '0;
      expectAddr_r <= 1'b0;
      ioActive_r <= 1'b0;
      live_r <= 1'b0;
      hold_r <= 1'b0;
      cfg_r <= 2'b00;
      rdData_r <= sphp_pkg::RST_ZERO;
      wait_r <= 1'b1;
      memRd_r <= 1'b0;
      memWr_r <= 1'b0;
      wrSample_r <= 12'h000;
      wrNorm_r <= 1'b0;
      pendRd_r <= 1'b0;
      memRdSeen_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      memAddr_r <= memAddr_nxt;
      expectAddr_r <= expectAddr_nxt;
      ioActive_r <= ioActive_nxt;
      live_r <= live_nxt;
      hold_r <= hold_nxt;
      cfg_r <= cfg_nxt;
      rdData_r <= rdData_nxt;
      wait_r <= wait_nxt;
      memRd_r <= memRd_nxt;
      memWr_r <= memWr_nxt;
      wrSample_r <= wrSample_nxt;
      wrNorm_r <= wrNorm_nxt;
      pendRd_r <= pendRd_nxt;
      // Memory answers one cycle after the read pulse
      memRdSeen_r <= memRd_r;
    end
  end

  // Advance mode walks displayed points from the left edge
  assign memAddr = memAddr_r;
  assign memRead = memRd_r;
  assign memWrite = memWr_r;
  assign memWrSample = wrSample_r;
  assign memWrNorm = wrNorm_r;
  assign avs_readdata = rdData_r;
  assign avs_waitrequest = wait_r;
  assign ioActive = ioActive_r;
  assign diskInhibit = ioActive_r;
  assign plugLive = live_r;
  assign plugHoldNext = hold_r;

  a_adv_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlWr && avs_writedata[15:0] == sphp_pkg::CTRL_ADV
    |=> mode_r == sphp_pkg::SPHP_ADV && addr_r == '0)
    else $error("Advance control did not clear counter");
  a_idle_off: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlWr && avs_writedata[15:0] == sphp_pkg::CTRL_IDLE
    |=> !ioActive && mode_r == sphp_pkg::SPHP_IDLE)
    else $error("Idle control left I/O active");
  a_disk_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ioActive |-> diskInhibit)
    else $error("Disk not inhibited while active");
  a_stat_none: assert property (@(posedge clk) disable iff (!rst_n)
    avs_read && avs_address == sphp_pkg::REG_STAT && wait_r && !pendRd_r
    && !anyLive && !diskAct |=> avs_readdata[15:0] == 16'h0120)
    else $error("Status value wrong");
  a_stat_live: assert property (@(posedge clk) disable iff (!rst_n)
    avs_read && avs_address == sphp_pkg::REG_STAT && wait_r && !pendRd_r
    && anyLive && !diskAct |=> avs_readdata[15:0] == 16'h0121)
    else $error("Live status value wrong");
  a_stat_disk: assert property (@(posedge clk) disable iff (!rst_n)
    avs_read && avs_address == sphp_pkg::REG_STAT && wait_r && !pendRd_r
    && !anyLive && diskAct |=> avs_readdata[15:0] == 16'h0020)
    else $error("Disk status value wrong");
  a_stat_both: assert property (@(posedge clk) disable iff (!rst_n)
    avs_read && avs_address == sphp_pkg::REG_STAT && wait_r && !pendRd_r
    && anyLive && diskAct |=> avs_readdata[15:0] == 16'h0021)
    else $error("Combined status value wrong");
  a_hold_live: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlWr && avs_writedata[15:0] == sphp_pkg::CTRL_HOLD
    |=> plugHoldNext && !plugLive)
    else $error("Hold-next control not applied");
  a_load_sel: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlWr && avs_writedata[15:0] == sphp_pkg::CTRL_LOAD
    && mode_r == sphp_pkg::SPHP_ADV |=> mode_r == sphp_pkg::SPHP_LOAD
    && expectAddr_r)
    else $error("Load control did not arm address word");
  a_load_alt: assert property (@(posedge clk) disable iff (!rst_n)
    fOutValid && fOutReady && mode_r == sphp_pkg::SPHP_LOAD
    && expectAddr_r |=> !expectAddr_r && !memWrite)
    else $error("Address word not taken as address");
  a_norm_pos: assert property (@(posedge clk) disable iff (!rst_n)
    pendRd_r && memRdSeen_r |=> avs_readdata[0] == $past(memRdNorm)
    && avs_readdata[15:12] == {4{$past(memRdSample[11])}})
    else $error("Read word format wrong");
  a_wr_fmt: assert property (@(posedge clk) disable iff (!rst_n)
    memWrite |-> memWrSample == $past(fOutData[12:1]))
    else $error("Written sample misplaced");
  a_one_ack: assert property (@(posedge clk) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("Acknowledge longer than one cycle");
  a_adv_step: assert property (@(posedge clk) disable iff (!rst_n)
    memRdSeen_r && mode_r == sphp_pkg::SPHP_ADV && !ctrlWr
    && !(fOutValid && fOutReady) |=> addr_r == $past(addr_r) + 1'b1)
    else $error("Counter did not step");
  a_adv_wstep: assert property (@(posedge clk) disable iff (!rst_n)
    memWrite && mode_r == sphp_pkg::SPHP_ADV && !ctrlWr
    |=> addr_r == $past(addr_r) + 1'b1)
    else $error("Counter did not step after write");

  // Fetch pulse with a read pending, then exactly one acknowledge cycle
  sequence s_rd_issue;
    pendRd_r && memRead;
  endsequence
  sequence s_rd_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_rd_ack: assert property (@(posedge clk) disable iff (!rst_n)
    s_rd_issue |-> ##2 s_rd_ack)
    else $error("Read data not acknowledged in time");
endmodule : sphp_top
`default_nettype wire

// [hw/sphp_pkg.sv]
// Constants for the scope parallel host port
// Behaviour
// - Control 34: advance mode, counter cleared
// - Advance mode: start leftmost, step per transfer
// - After 34 then 35: address, data alternate
// - Decode controls 35,34,33,32,0
// - Control 0 ends I/O, active off
// - Disk inhibited while I/O active
// - Load addresses follow memory group ranges
// - Status 288,289,32,33 from live and disk
// - Sample and norm bit in one word
// - Sample bits 15..1, sign fills top four
// - Norm bit at word bit 0
package sphp_pkg;
  localparam logic [15:0] CTRL_LOAD = 16'h0023;
  localparam logic [15:0] CTRL_ADV = 16'h0022;
  localparam logic [15:0] CTRL_LIVE = 16'h0021;
  localparam logic [15:0] CTRL_HOLD = 16'h0020;
  localparam logic [15:0] CTRL_IDLE = 16'h0000;
  localparam logic [15:0] STAT_NONE = 16'h0120;
  localparam logic [15:0] STAT_LIVE = 16'h0121;
  localparam logic [15:0] STAT_DISK = 16'h0020;
  localparam logic [15:0] STAT_BOTH = 16'h0021;
  localparam logic [11:0] ADDR_START = 12'h800;
  localparam int SIGN_POS = 11;
  localparam int NORM_POS = 0;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_CFG = 4'hc;
  localparam int CFG_LIVE = 0;
  localparam int CFG_DISK = 1;
  localparam int FIFO_DEPTH = 16;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  typedef enum logic [2:0] {
    SPHP_IDLE = 3'b001,
    SPHP_ADV = 3'b010,
    SPHP_LOAD = 3'b100
  } sphp_mode_type;
endpackage : sphp_pkg

// [hw/sphp_fifo.sv]
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sphp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic inValid, // Fill side valid
  output logic inReady, // Fill side ready
  input wire logic [WIDTH-1:0] inData, // Fill side word
  output logic outValid, // Drain side valid
  input wire logic outReady, // Drain side ready
  output logic [WIDTH-1:0] outData // Drain side word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push, pop;
  always_comb begin
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
endmodule : sphp_fifo
`default_nettype wire

// [tb/sphp_mem_model.sv]
// Behavioural waveform memory on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module sphp_mem_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [11:0] memAddr, // Word address
  input wire logic memRead, // Read pulse
  input wire logic memWrite, // Write pulse
  input wire logic [11:0] memWrSample, // Sample in
  input wire logic memWrNorm, // Norm bit in
  output logic [11:0] memRdSample, // Sample out
  output logic memRdNorm // Norm bit out
);
  logic [12:0] store [4096];
  logic [12:0] lastWord;
  logic [1:0] holdLeft;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      store[i] = {i[0] ^ i[5], i[11:0] ^ 12'h5a3};
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdLeft <= 2'h0;
      lastWord <= 13'h0000;
    end else begin
      if (memWrite) store[memAddr] <= {memWrNorm, memWrSample};
      if (memRead) begin
        lastWord <= store[memAddr];
        holdLeft <= 2'h2;
      end else if (holdLeft != 2'h0) begin
        holdLeft <= holdLeft - 2'h1;
      end
    end
  end
  // Hold window over: show the inverse so stale data cannot pass
  assign {memRdNorm, memRdSample} = (holdLeft != 2'h0) ? lastWord : ~lastWord;
endmodule : sphp_mem_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the scope parallel host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, memRead, memWrite;
  logic memWrNorm, memRdNorm, diskActivePin, ioActive, diskInhibit;
  logic plugLive, plugHoldNext;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [11:0] memAddr, memWrSample, memRdSample, screenLeft, screenStep;
  logic [12:0] shadow [4096];
  logic [12:0] e;
  int failCount = 0;
  int nCompared = 0;
  int corner [4] = '{-2048, 2047, -2045, 2044};
  int a;
  sphp_top uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
    .memWrSample(memWrSample), .memWrNorm(memWrNorm),
    .memRdSample(memRdSample), .memRdNorm(memRdNorm),
    .screenLeft(screenLeft), .screenStep(screenStep),
    .diskActivePin(diskActivePin), .ioActive(ioActive),
    .diskInhibit(diskInhibit), .plugLive(plugLive),
    .plugHoldNext(plugHoldNext));
  sphp_mem_model mem (.clk(clk), .rst_n(rst_n), .memAddr(memAddr),
    .memRead(memRead), .memWrite(memWrite), .memWrSample(memWrSample),
    .memWrNorm(memWrNorm), .memRdSample(memRdSample), .memRdNorm(memRdNorm));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Host word: sign in top four, sample below, norm in bit 0
  function automatic logic [15:0] fmt(input logic [12:0] w);
    return {{4{w[11]}}, w[10:0], w[12]};
  endfunction
  function automatic logic [15:0] stat(input logic live, input logic disk);
    if (disk) return live ? 16'h0021 : 16'h0020;
    return live ? 16'h0121 : 16'h0120;
  endfunction
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer; held until waitrequest is seen low at a rising edge, or failed after 400 cycles
  task automatic bus(input logic wr, input logic [3:0] ad,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 400);
    if (n >= 400) chk(32'h1, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  initial begin
    repeat (30000) @(posedge clk);
    failCount++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    diskActivePin = 1'b0;
    screenLeft = 12'h000;
    screenStep = 12'h001;
    for (int i = 0; i < 4096; i++) shadow[i] = {i[0] ^ i[5], i[11:0] ^ 12'h5a3};
    void'($urandom(32'h2925));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({avs_waitrequest, ioActive, avs_readdata[29:0]}, {2'b10, 30'h0});
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 4'hc, 16'(c));
      bus(1'b0, 4'h8, 16'h0000);
      chk(q, {16'h0000, stat(c[0], c[1])});
    end
    bus(1'b1, 4'hc, 16'h0000);
    diskActivePin <= 1'b1;
    bus(1'b0, 4'h8, 16'h0000);
    bus(1'b0, 4'h8, 16'h0000);
    chk(q, {16'h0000, stat(1'b0, 1'b1)});
    diskActivePin <= 1'b0;
    bus(1'b0, 4'h6, 16'h0000);
    chk(q, 32'h0);
    screenLeft <= 12'($urandom);
    screenStep <= 12'($urandom_range(1, 9));
    bus(1'b1, 4'h0, 16'h0022);
    chk({ioActive, diskInhibit}, 2'b11);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 4'h4, 16'h0000);
      chk(q, fmt(shadow[12'(screenLeft + i * screenStep)]));
    end
    bus(1'b1, 4'h0, 16'h0022);
    bus(1'b0, 4'h4, 16'h0000);
    chk(q, fmt(shadow[screenLeft]));
    bus(1'b1, 4'h0, 16'h0022);
    // More words than the buffer holds, sent back to back
    for (int i = 0; i < 18; i++) begin
      e = 13'($urandom);
      shadow[12'(screenLeft + i * screenStep)] = e;
      bus(1'b1, 4'h4, fmt(e));
    end
    bus(1'b1, 4'h0, 16'h0022);
    for (int i = 0; i < 18; i++) begin
      bus(1'b0, 4'h4, 16'h0000);
      chk(q, fmt(shadow[12'(screenLeft + i * screenStep)]));
    end
    bus(1'b1, 4'h0, 16'h0022);
    bus(1'b1, 4'h0, 16'h0023);
    for (int k = 0; k < 10; k++) begin
      a = (k < 4) ? corner[k] : int'($urandom_range(0, 4095)) - 2048;
      e = 13'($urandom);
      shadow[12'(a + 2048)] = e;
      bus(1'b1, 4'h4, 16'(a * 2));
      bus(1'b1, 4'h4, fmt(e));
      bus(1'b1, 4'h4, 16'(a * 2));
      bus(1'b0, 4'h4, 16'h0000);
      chk(q, fmt(shadow[12'(a + 2048)]));
      chk({17'h0, q[15:1]}, {17'h0, {4{e[11]}}, e[10:0]});
    end
    bus(1'b1, 4'h0, 16'h0021);
    chk({plugLive, plugHoldNext}, 2'b10);
    bus(1'b1, 4'h0, 16'h0020);
    chk({plugLive, plugHoldNext}, 2'b01);
    bus(1'b1, 4'h0, 16'h0000);
    chk({ioActive, diskInhibit}, 2'b00);
    bus(1'b1, 4'h0, 16'h0022);
    // Reset in a live session must drop the indicator within two clock edges
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({avs_waitrequest, ioActive, diskInhibit, avs_readdata[28:0]},
        {3'b100, 29'h0});
    rst_n <= 1'b1;
    bus(1'b0, 4'h8, 16'h0000);
    chk(q, {16'h0000, stat(1'b0, 1'b0)});
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
